//--- rtl/ict_pkg.sv
/*
  Constants and types for the instruction cycle timing block.
  Assumes a core that presents one decoded instruction class per cycle.
*/
package ict_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned PHASES_PER_CYCLE = 4;
  localparam int unsigned PHASE_W = 2;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_DECODE = 2'h0;
  localparam logic [1:0] PHASE_EXEC = 2'h3;
  // ==========================================================
  // Data
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 14;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [13:0] PC_RESET = 14'h0000;
  localparam int unsigned STACK_DEPTH = 12;
  // ==========================================================
  // Operation codes presented to the block
  typedef enum logic [4:0] {
    ICT_OP_NOP = 5'h00,
    ICT_OP_ADD = 5'h01,
    ICT_OP_ADC = 5'h02,
    ICT_OP_SUB = 5'h03,
    ICT_OP_SBC = 5'h04,
    ICT_OP_AND = 5'h05,
    ICT_OP_OR = 5'h06,
    ICT_OP_XOR = 5'h07,
    ICT_OP_CPL = 5'h08,
    ICT_OP_INC = 5'h09,
    ICT_OP_DEC = 5'h0A,
    ICT_OP_MOV_TO_ACC = 5'h0B,
    ICT_OP_MOV_TO_MEM = 5'h0C,
    ICT_OP_MOV_IMM = 5'h0D,
    ICT_OP_JUMP = 5'h0E,
    ICT_OP_CALL = 5'h0F,
    ICT_OP_RET = 5'h10,
    ICT_OP_INTERRUPT_EXIT_OP = 5'h11,
    ICT_OP_TABLE_RD = 5'h12,
    ICT_OP_SKIP_Z = 5'h13,
    ICT_OP_SKIP_NZ = 5'h14
  } ict_op_t;
  // ==========================================================
  // Sequencer states
  typedef enum logic [0:0] {
    ICT_ST_RUN = 1'b0,
    ICT_ST_FLUSH = 1'b1
  } ict_state_t;
endpackage

//--- rtl/ict_alu_if.sv
/*
  Interface carrying operands and results between the sequencer and
  its arithmetic unit. Assumes one clock; purely combinational links.
*/
`timescale 1ns/1ps
interface ict_alu_if;
  logic [4:0] op;
  logic [7:0] acc;
  logic [7:0] mem;
  logic [7:0] imm;
  logic use_imm;
  logic carry_in;
  logic [7:0] result;
  logic carry_out;
  logic carry_upd;
  logic zero_out;
  logic zero_upd;
  logic to_mem;
  logic to_acc;
  modport seq (output op, acc, mem, imm, use_imm, carry_in,
    input result, carry_out, carry_upd, zero_out, zero_upd, to_mem, to_acc);
  modport alu (input op, acc, mem, imm, use_imm, carry_in,
    output result, carry_out, carry_upd, zero_out, zero_upd, to_mem, to_acc);
endinterface

//--- rtl/ict_alu.sv
/*
  Eight-bit arithmetic and logic unit of the core.
  Assumes operands are stable within the instruction cycle.
*/
`timescale 1ns/1ps
module ict_alu (
  ict_alu_if.alu a,
  input wire logic to_mem_sel
);
  // ==========================================================
  // Operand selection
  wire logic [7:0] opnd = a.use_imm ? a.imm : a.mem;
  wire logic [8:0] sum = {1'b0, a.acc} + {1'b0, opnd}
    + {8'h00, (a.op == 5'h02) & a.carry_in};
  // Borrow when acc - opnd (- not carry) drops below zero
  wire logic [8:0] diff = {1'b0, a.acc} - {1'b0, opnd}
    - {8'h00, (a.op == 5'h04) & ~a.carry_in};
  wire logic is_add = a.op == 5'h01 || a.op == 5'h02;
  wire logic is_sub = a.op == 5'h03 || a.op == 5'h04;
  wire logic is_logic = a.op >= 5'h05 && a.op <= 5'h08;
  wire logic is_step = a.op == 5'h09 || a.op == 5'h0A;
  wire logic is_arith = is_add || is_sub;
  // ==========================================================
  // Result selection
  always_comb
  begin
    unique case (a.op)
      5'h01, 5'h02: a.result = sum[7:0]; // RL6
      5'h03, 5'h04: a.result = diff[7:0]; // RL6
      5'h05: a.result = a.acc & opnd;
      5'h06: a.result = a.acc | opnd;
      5'h07: a.result = a.acc ^ opnd;
      5'h08: a.result = ~a.mem;
      5'h09: a.result = a.mem + 8'h01; // RL7
      5'h0A: a.result = a.mem - 8'h01; // RL7
      5'h0B: a.result = a.mem; // RL8
      5'h0C: a.result = a.acc; // RL8
      5'h0D: a.result = a.imm; // RL8
      default: a.result = a.mem;
    endcase
  end
  // Carry set on sum over 255, cleared on borrow below 0
  assign a.carry_out = is_add ? sum[8] : ~diff[8]; // RL6
  assign a.carry_upd = is_arith;
  // Logic ops touch only zero, never carry
  assign a.zero_out = a.result == 8'h00; // RL9
  assign a.zero_upd = is_arith || is_logic || is_step; // RL9
  assign a.to_mem = a.op == 5'h0C || ((is_step || a.op == 5'h08)
    && to_mem_sel); // RL7
  assign a.to_acc = (a.op >= 5'h01 && a.op <= 5'h0D && a.op != 5'h0C
    && !((is_step || a.op == 5'h08) && to_mem_sel)); // RL7
endmodule

//--- rtl/ict_core.sv
/*
  Instruction cycle sequencer: phase counter, program counter, return
  stack, flags and accumulator of an 8-bit core.
  Assumes instruction words are fetched by the surroundings from
  FETCH_ADDR and presented decoded on OP and the operand ports; data
  memory answers MEM_RDATA combinationally for the operand address.
*/
`timescale 1ns/1ps
// How it works
// RL1: Every instruction cycle is four system clocks, counted by a phase.
// RL2: Ordinary data operations retire in one instruction cycle.
// RL3: Jump, call, return, interrupt return and table read take two cycles.
// RL4: A write to the program counter low byte jumps and adds one cycle.
// RL5: A skip costs one cycle, plus one more when the next op is skipped.
// RL6: Add and subtract are 8-bit, carry above 255, borrow below 0.
// RL7: Increment and decrement change by one, to memory or accumulator.
// RL8: Moves go memory to acc, acc to memory, or constant to acc.
// RL9: Logic operations set zero on a zero result and keep carry.
// RL10: A return resumes at the address after the calling instruction.
// RL11: The extra cycle discards the prefetched op and fetches anew.
module ict_core #(
  parameter int unsigned DEPTH = ict_pkg::STACK_DEPTH
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [4:0] OP,
  input wire logic [7:0] IMM,
  input wire logic USE_IMM,
  input wire logic TO_MEM,
  input wire logic [13:0] TARGET,
  input wire logic [7:0] MEM_RDATA,
  input wire logic MEM_IS_PCL,
  input wire logic [2:0] BIT_SEL,
  input wire logic BIT_TEST,
  output logic [13:0] FETCH_ADDR,
  output logic [1:0] PHASE,
  output logic RETIRE,
  output logic FLUSH,
  output logic MEM_WE,
  output logic [7:0] MEM_WDATA,
  output logic TABLE_RD,
  output logic [7:0] ACC,
  output logic CARRY,
  output logic ZERO,
  output logic INT_ENABLE
);
  // ==========================================================
  // State
  logic [1:0] phase_ff;
  ict_pkg::ict_state_t state_ff;
  logic [13:0] pc_ff;
  logic [7:0] acc_ff;
  logic carry_ff;
  logic zero_ff;
  logic inten_ff;
  logic [13:0] stack_ff [DEPTH];
  logic [3:0] sp_ff;
  logic retire_ff;
  logic flush_ff;
  logic we_ff;
  logic [7:0] wdata_ff;
  logic tbl_ff;
  ict_alu_if alu_bus ();
  // ==========================================================
  // Arithmetic unit link
  assign alu_bus.op = OP;
  assign alu_bus.acc = acc_ff;
  assign alu_bus.mem = MEM_RDATA;
  assign alu_bus.imm = IMM;
  assign alu_bus.use_imm = USE_IMM;
  assign alu_bus.carry_in = carry_ff;
  ict_alu u_alu (
    .a(alu_bus.alu),
    .to_mem_sel(TO_MEM)
  );
  // ==========================================================
  // Decode of the current instruction
  wire logic exec = phase_ff == ict_pkg::PHASE_EXEC; // RL1
  wire logic run = state_ff == ict_pkg::ICT_ST_RUN;
  wire logic do_exec = exec && run;
  wire logic is_jump = OP == ict_pkg::ICT_OP_JUMP;
  wire logic is_call = OP == ict_pkg::ICT_OP_CALL;
  wire logic is_ret = OP == ict_pkg::ICT_OP_RET;
  wire logic is_interrupt_exit_op = OP == ict_pkg::ICT_OP_INTERRUPT_EXIT_OP;
  wire logic is_tbl = OP == ict_pkg::ICT_OP_TABLE_RD;
  wire logic is_skip = OP == ict_pkg::ICT_OP_SKIP_Z
    || OP == ict_pkg::ICT_OP_SKIP_NZ;
  // Bit test reads one operand bit, else the whole byte
  wire logic tested = BIT_TEST ? MEM_RDATA[BIT_SEL] : |MEM_RDATA;
  wire logic skip_hit = is_skip
    && ((OP == ict_pkg::ICT_OP_SKIP_Z) ? !tested : tested); // RL5
  wire logic pcl_write = alu_bus.to_mem && MEM_IS_PCL; // RL4
  wire logic is_return = is_ret || is_interrupt_exit_op;
  wire logic sp_empty = sp_ff == 4'h0;
  wire logic [13:0] pc_inc = pc_ff + 14'h0001;
  wire logic [13:0] ret_addr = stack_ff[sp_ff - 4'h1];
  wire logic two_cycle = is_jump || is_call || is_return || is_tbl
    || pcl_write || skip_hit; // RL3 RL4 RL5
  // Next program counter; skip passes over the prefetched op
  wire logic [13:0] nxt_pc = (is_jump || is_call) ? TARGET
    : is_return ? (sp_empty ? pc_ff : ret_addr) // RL10
    : pcl_write ? {pc_ff[13:8], alu_bus.result} // RL4
    : skip_hit ? pc_inc // RL5
    : pc_ff; // RL3
  // Ordinary ops step on; two-cycle ops take nxt_pc, and a table
  // read holds the PC so that its flush cycle fetches the next op again
  wire logic [13:0] nxt_seq = two_cycle ? nxt_pc : pc_inc; // RL3 RL11
  wire logic [1:0] nxt_phase = phase_ff + 2'h1; // RL1
  // ==========================================================
  // Phase counter, four clocks per instruction cycle
  // Wraps from three to zero; strobes fall in phase zero
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      phase_ff <= ict_pkg::PHASE_RESET;
    else
      phase_ff <= nxt_phase; // RL1
  end
  // ==========================================================
  // Sequencer: flush state inserts the discarded fetch cycle
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      state_ff <= ict_pkg::ICT_ST_RUN;
    else if (exec)
    begin
      unique case (state_ff)
        ict_pkg::ICT_ST_RUN:
          state_ff <= two_cycle ? ict_pkg::ICT_ST_FLUSH
            : ict_pkg::ICT_ST_RUN; // RL3 RL11
        ict_pkg::ICT_ST_FLUSH:
          state_ff <= ict_pkg::ICT_ST_RUN; // RL11
      endcase
    end
  end
  // ==========================================================
  // Program counter
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      pc_ff <= ict_pkg::PC_RESET;
    else if (do_exec)
      pc_ff <= nxt_seq; // RL11
    else if (exec)
      pc_ff <= pc_inc; // RL11
  end
  // ==========================================================
  // Return stack; call pushes the address after itself
  // A full stack drops the push; an empty one leaves the PC on return
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      sp_ff <= 4'h0;
    else if (do_exec && is_call && sp_ff != 4'(DEPTH))
      sp_ff <= sp_ff + 4'h1;
    else if (do_exec && is_return && !sp_empty)
      sp_ff <= sp_ff - 4'h1;
  end
  // Stack entries hold no reset; only pushed slots are ever read
  always_ff @(posedge SYS_CLK)
  begin
    if (do_exec && is_call && sp_ff != 4'(DEPTH))
      stack_ff[sp_ff] <= pc_ff; // RL10
  end
  // ==========================================================
  // Accumulator and flags
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      acc_ff <= ict_pkg::ACC_RESET;
      carry_ff <= 1'b0;
      zero_ff <= 1'b0;
      inten_ff <= 1'b0;
    end
    else if (do_exec)
    begin
      if (alu_bus.to_acc)
        acc_ff <= alu_bus.result; // RL8
      if (alu_bus.carry_upd)
        carry_ff <= alu_bus.carry_out; // RL6
      if (alu_bus.zero_upd)
        zero_ff <= alu_bus.zero_out; // RL9
      // Interrupt return opens interrupts again
      if (is_interrupt_exit_op)
        inten_ff <= 1'b1;
    end
  end
  // ==========================================================
  // Strobes to the surroundings
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      retire_ff <= 1'b0;
      flush_ff <= 1'b0;
      we_ff <= 1'b0;
      wdata_ff <= 8'h00;
      tbl_ff <= 1'b0;
    end
    else
    begin
      retire_ff <= exec && (run ? !two_cycle : 1'b1); // RL2 RL3
      flush_ff <= do_exec && two_cycle; // RL11
      // Write data follows the unit every clock; only the strobe counts
      we_ff <= do_exec && alu_bus.to_mem; // RL7
      wdata_ff <= alu_bus.result;
      tbl_ff <= do_exec && is_tbl;
    end
  end
  assign FETCH_ADDR = pc_ff;
  assign PHASE = phase_ff;
  assign RETIRE = retire_ff;
  assign FLUSH = flush_ff;
  assign MEM_WE = we_ff;
  assign MEM_WDATA = wdata_ff;
  assign TABLE_RD = tbl_ff;
  assign ACC = acc_ff;
  assign CARRY = carry_ff;
  assign ZERO = zero_ff;
  assign INT_ENABLE = inten_ff;
endmodule

//--- testbench/ict_core_monitor.sv
/*
  Port checker of the instruction cycle timing core.
  Assumes binding to ict_core; one clock, reset async active high.
*/
`timescale 1ns/1ps
module ict_monitor (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [4:0] OP,
  input wire logic USE_IMM,
  input wire logic TO_MEM,
  input wire logic [7:0] MEM_RDATA,
  input wire logic MEM_IS_PCL,
  input wire logic [13:0] FETCH_ADDR,
  input wire logic [1:0] PHASE,
  input wire logic RETIRE,
  input wire logic FLUSH,
  input wire logic MEM_WE,
  input wire logic [7:0] MEM_WDATA,
  input wire logic TABLE_RD,
  input wire logic [7:0] ACC,
  input wire logic CARRY,
  input wire logic ZERO
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // ==========================================================
  // Flush cycle tracker: its op is discarded, never executed
  logic fl_ff;
  logic nxt_fl;
  wire exe = (PHASE == 2'h3) && !fl_ff;
  assign nxt_fl = FLUSH ? 1'h1 : ((PHASE == 2'h3) ? 1'h0 : fl_ff);
  always_ff @(posedge SYS_CLK or posedge RST)
    if (RST) fl_ff <= 1'h0;
    else fl_ff <= nxt_fl;
  // ==========================================================
  // Assertions
  a_phase_step: assert property
    (!$past(RST) |-> PHASE == $past(PHASE) + 2'h1)
    else $error("phase did not step by one");
  a_pulse_phase: assert property
    (RETIRE || FLUSH || MEM_WE || TABLE_RD |-> PHASE == 2'h0)
    else $error("pulse outside phase zero");
  a_state_stand: assert property (PHASE != 2'h0 |->
    $stable(FETCH_ADDR) && $stable(ACC) && $stable({CARRY, ZERO}))
    else $error("state changed inside a cycle");
  a_plain_one: assert property
    (exe && OP <= 5'h0D && !MEM_IS_PCL |=> RETIRE && !FLUSH)
    else $error("plain op did not retire in one cycle");
  a_flow_two: assert property (exe && OP >= 5'h0E && OP <= 5'h12
    |=> (FLUSH && !RETIRE) ##4 RETIRE)
    else $error("flow op not two cycles");
  a_pcl_jump: assert property
    (exe && MEM_IS_PCL && OP == 5'h0C |=> FLUSH ##4 RETIRE)
    else $error("low pc write did not add a cycle");
  a_add_carry: assert property (exe && OP == 5'h01 && !USE_IMM
    |=> {CARRY, ACC} == {1'h0, $past(ACC)} + {1'h0, $past(MEM_RDATA)})
    else $error("add result or carry wrong");
  a_logic_keep: assert property (exe && OP >= 5'h05 && OP <= 5'h07
    |=> $stable(CARRY) && (ZERO == (ACC == 8'h00)))
    else $error("logic op flags wrong");
  a_inc_mem: assert property (exe && OP == 5'h09 && TO_MEM && !USE_IMM
    |=> MEM_WE && MEM_WDATA == $past(MEM_RDATA) + 8'h01)
    else $error("increment to memory wrong");
endmodule

//--- testbench/tb.sv
/*
  Self-checking bench of the instruction cycle timing core.
  Assumes ict_pkg, ict_core and ict_monitor compiled first.
*/
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Case row: op, operand, {use_imm, to_mem}, result,
  // {carry, zero}, clocks to retire
  typedef struct packed {
    logic [4:0] op;
    logic [7:0] v;
    logic [1:0] it;
    logic [7:0] ea;
    logic [1:0] cz;
    logic [3:0] n;
  } ict_row_t;
  logic SYS_CLK = 1'h0;
  logic RST = 1'h1;
  logic [4:0] OP = 5'h00;
  logic [7:0] IMM = 8'h00;
  logic [7:0] MEM_RDATA = 8'h00;
  logic USE_IMM = 1'h0;
  logic TO_MEM = 1'h0;
  logic MEM_IS_PCL = 1'h0;
  logic [13:0] TARGET = 14'h0000;
  logic [2:0] BIT_SEL = 3'h0;
  logic BIT_TEST = 1'h0;
  logic [13:0] FETCH_ADDR;
  logic [1:0] PHASE;
  logic RETIRE, FLUSH, MEM_WE, TABLE_RD, CARRY, ZERO, INT_ENABLE;
  logic [7:0] MEM_WDATA, ACC;
  logic [13:0] pa;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  // Op codes as numbered in ict_op_t
  localparam ict_row_t ROWS [19] = '{
    '{5'h0D, 8'hF0, 2'h2, 8'hF0, 2'h0, 4'h4},
    '{5'h01, 8'h20, 2'h0, 8'h10, 2'h2, 4'h4},
    '{5'h05, 8'h0F, 2'h2, 8'h00, 2'h3, 4'h4},
    '{5'h06, 8'h5A, 2'h0, 8'h5A, 2'h2, 4'h4},
    '{5'h07, 8'h5A, 2'h2, 8'h00, 2'h3, 4'h4},
    '{5'h03, 8'h01, 2'h0, 8'hFF, 2'h0, 4'h4},
    '{5'h03, 8'h0F, 2'h2, 8'hF0, 2'h2, 4'h4},
    '{5'h09, 8'hFF, 2'h0, 8'h00, 2'h3, 4'h4},
    '{5'h0A, 8'h00, 2'h0, 8'hFF, 2'h2, 4'h4},
    '{5'h09, 8'h7F, 2'h1, 8'h80, 2'h2, 4'h4},
    '{5'h08, 8'hFF, 2'h0, 8'h00, 2'h3, 4'h4},
    '{5'h02, 8'hC4, 2'h0, 8'hC5, 2'h0, 4'h4},
    '{5'h0C, 8'h00, 2'h1, 8'hC5, 2'h0, 4'h4},
    '{5'h0B, 8'h00, 2'h0, 8'h00, 2'h0, 4'h4},
    '{5'h13, 8'h00, 2'h0, 8'h00, 2'h0, 4'h8},
    '{5'h13, 8'h01, 2'h0, 8'h00, 2'h0, 4'h4},
    '{5'h14, 8'h00, 2'h0, 8'h00, 2'h0, 4'h4},
    '{5'h12, 8'h00, 2'h0, 8'h00, 2'h0, 4'h8},
    '{5'h11, 8'h00, 2'h0, 8'h00, 2'h0, 4'h8}
  };
  ict_core uut (.SYS_CLK(SYS_CLK), .RST(RST), .OP(OP), .IMM(IMM),
    .USE_IMM(USE_IMM), .TO_MEM(TO_MEM), .TARGET(TARGET),
    .MEM_RDATA(MEM_RDATA), .MEM_IS_PCL(MEM_IS_PCL), .BIT_SEL(BIT_SEL),
    .BIT_TEST(BIT_TEST), .FETCH_ADDR(FETCH_ADDR), .PHASE(PHASE),
    .RETIRE(RETIRE), .FLUSH(FLUSH), .MEM_WE(MEM_WE),
    .MEM_WDATA(MEM_WDATA), .TABLE_RD(TABLE_RD), .ACC(ACC),
    .CARRY(CARRY), .ZERO(ZERO), .INT_ENABLE(INT_ENABLE));
  // Clock and hang guard
  always #20 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      final_report();
    end
  end
  task automatic chk(input string s, input logic [13:0] e,
    input logic [13:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // One op from phase zero until it retires
  task automatic run(input ict_row_t r);
    logic [7:0] a0;
    logic [7:0] wd;
    logic tr;
    int n;
    a0 = ACC;
    wd = 8'h00;
    tr = 1'h0;
    n = 0;
    OP = r.op;
    IMM = r.v;
    MEM_RDATA = r.v;
    {USE_IMM, TO_MEM} = r.it;
    do
    begin
      @(posedge SYS_CLK);
      #1;
      n++;
      if (MEM_WE === 1'h1) wd = MEM_WDATA;
      if (TABLE_RD === 1'h1) tr = 1'h1;
      // A no-op fills the discarded cycle; a plain op is left standing
      if (n == 4 && RETIRE !== 1'h1) OP = 5'h00;
    end
    while (RETIRE !== 1'h1 && n < 12);
    chk("clocks", 14'(r.n), 14'(n));
    chk("acc", 14'(r.it[0] ? a0 : r.ea), 14'(ACC));
    chk("write", 14'(r.it[0] ? r.ea : 8'h00), 14'(wd));
    chk("flags", 14'(r.cz), 14'({CARRY, ZERO}));
    chk("table", 14'(r.op == 5'h12), 14'(tr));
    $display("op %h done", r.op);
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge SYS_CLK);
    #1;
    chk("reset pc", 14'h0000, FETCH_ADDR);
    chk("reset out", 14'h0000, {PHASE, ACC, CARRY, ZERO, INT_ENABLE, FLUSH});
    $display("reset test done");
    RST = 1'h0;
    foreach (ROWS[i]) run(ROWS[i]);
    chk("int enable", 14'h0001, 14'(INT_ENABLE));
    // Jump at the top of program memory wraps round
    TARGET = 14'h3FFF;
    run('{5'h0E, 8'h00, 2'h0, 8'h00, 2'h0, 4'h8});
    chk("jump pc", 14'h0000, FETCH_ADDR);
    pa = FETCH_ADDR;
    TARGET = 14'h0123;
    run('{5'h0F, 8'h00, 2'h0, 8'h00, 2'h0, 4'h8});
    chk("call pc", 14'h0124, FETCH_ADDR);
    run('{5'h10, 8'h00, 2'h0, 8'h00, 2'h0, 4'h8});
    chk("ret pc", pa + 14'h0001, FETCH_ADDR);
    // Accumulator written to the low program counter byte
    run('{5'h0D, 8'h40, 2'h2, 8'h40, 2'h0, 4'h4});
    pa = FETCH_ADDR;
    MEM_IS_PCL = 1'h1;
    run('{5'h0C, 8'h00, 2'h1, 8'h40, 2'h0, 4'h8});
    MEM_IS_PCL = 1'h0;
    chk("pcl pc", {pa[13:8], 8'h41}, FETCH_ADDR);
    // Subtract with carry: clear carry borrows one more
    run('{5'h04, 8'h10, 2'h0, 8'h2F, 2'h2, 4'h4});
    // Single-bit skips, then a table read that must not skip
    BIT_TEST = 1'h1;
    BIT_SEL = 3'h4;
    pa = FETCH_ADDR;
    run('{5'h14, 8'h10, 2'h0, 8'h2F, 2'h2, 4'h8});
    chk("skip pc", pa + 14'h0002, FETCH_ADDR);
    run('{5'h13, 8'h10, 2'h0, 8'h2F, 2'h2, 4'h4});
    BIT_TEST = 1'h0;
    pa = FETCH_ADDR;
    run('{5'h12, 8'h00, 2'h0, 8'h2F, 2'h2, 4'h8});
    chk("table pc", pa + 14'h0001, FETCH_ADDR);
    // Reset in mid-run, then a fresh add
    RST = 1'h1;
    @(posedge SYS_CLK);
    #1;
    chk("rerun pc", 14'h0000, FETCH_ADDR);
    RST = 1'h0;
    run('{5'h01, 8'h7F, 2'h0, 8'h7F, 2'h0, 4'h4});
    final_report();
  end
endmodule
bind ict_core ict_monitor u_mon (.SYS_CLK(SYS_CLK), .RST(RST), .OP(OP),
  .USE_IMM(USE_IMM), .TO_MEM(TO_MEM), .MEM_RDATA(MEM_RDATA),
  .MEM_IS_PCL(MEM_IS_PCL), .FETCH_ADDR(FETCH_ADDR), .PHASE(PHASE),
  .RETIRE(RETIRE), .FLUSH(FLUSH), .MEM_WE(MEM_WE),
  .MEM_WDATA(MEM_WDATA), .TABLE_RD(TABLE_RD), .ACC(ACC),
  .CARRY(CARRY), .ZERO(ZERO));
